// ### verilog/tmr8_timer.sv
/*
  8-bit timer/counter: interval timer with toggling output, free-running
  pwm output and edge capture of the count, with pending flags.
  assumes a byte register port on mclk_i and an asynchronous capture pin.
*/
// Functional notes
// - reset clears control: interval, divide 1024, irqs off
// - clock selectable 1024, 256, 64, 8, 1
// - counter, comparator, reference all eight bits
// - control bit 2 written one clears counter
// - match/capture request only when bit 1 set
// - match/capture sets pending bit 4, software clears
// - interval match raises request, resets counter
// - interval match inverts toggle output
// - pwm counter free runs and wraps
// - pwm low when reference not above count
// - pwm period is 256 input ticks
// - capture edge copies count into reference
// - capture source select 00 picks pin
// - capture mode raises overflow request
// - capture mode raises capture request on load
`timescale 1ns/1ps
module tmr8_timer (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // pins
  input wire logic capture_input_pin_i,
  output logic toggle_output_pin_o,
  output logic pulse_output_pin_o,
  // interrupt requests
  output logic match_capture_irq_o,
  output logic overflow_irq_o
);
  tmr8_pkg::timer_state_t st; // registered state
  tmr8_pkg::timer_state_t next_st; // next state
  logic tick; // one selected input clock period
  logic cap_rise; // filtered rising edge
  logic cap_fall; // filtered falling edge
  tmr8_pkg::tmr_mode_t mode; // decoded mode
  logic wr_ctl; // control write strobe
  logic wr_pend; // pending write strobe
  logic match; // comparator hit on a tick
  logic wrap; // overflow on a tick
  logic cap_ev; // capture taken this cycle
  logic mc_ev; // match/capture request event
  logic ov_ev; // overflow request event

  // divider with ratio multiplexer
  tmr8_prescaler u_presc (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .sel_i(st.ctl[tmr8_pkg::clk_sel_lsb +: 3]),
    .tick_o(tick)
  );

  // capture pin synchroniser
  tmr8_pin_sync u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(capture_input_pin_i),
    .rise_o(cap_rise),
    .fall_o(cap_fall)
  );

  // mode and event decode
  always_comb begin
    mode = tmr8_pkg::tmr_mode_t'(st.ctl[tmr8_pkg::mode_lsb +: 2]);
    wr_ctl = reg_wr_i && (reg_addr_i == tmr8_pkg::timer_control_off);
    wr_pend = reg_wr_i && (reg_addr_i == tmr8_pkg::shared_pending_flags_off);
    match = tick && (st.cnt == st.refv);
    wrap = tick && (st.cnt == tmr8_pkg::count_max) && !(mode == tmr8_pkg::mode_interval && match);
    cap_ev = 1'b0;
    // only source 00 is wired; other codes leave capture idle
    if (st.portc[tmr8_pkg::cap_sel_lsb +: 2] == tmr8_pkg::cap_sel_pin) begin
      case (mode)
        tmr8_pkg::mode_cap_rise: cap_ev = cap_rise;
        tmr8_pkg::mode_cap_fall: cap_ev = cap_fall;
        default: cap_ev = 1'b0;
      endcase
    end
    // match events in interval and pwm, loads in capture
    case (mode)
      tmr8_pkg::mode_cap_rise, tmr8_pkg::mode_cap_fall: mc_ev = cap_ev;
      default: mc_ev = match;
    endcase
    mc_ev = mc_ev && st.ctl[tmr8_pkg::match_ie_bit];
    ov_ev = wrap && st.ctl[tmr8_pkg::ovf_ie_bit];
  end

  // next state: registers, counter, outputs, flags
  always_comb begin
    next_st = st;
    // software writes
    if (wr_ctl) begin
      next_st.ctl = reg_wdata_i;
      next_st.ctl[tmr8_pkg::clear_bit] = 1'b0; // clear bit is a strobe
    end
    if (reg_wr_i && reg_addr_i == tmr8_pkg::timer_reference_value_off) begin
      next_st.refv = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == tmr8_pkg::port_control_mid_off) begin
      next_st.portc = reg_wdata_i;
    end
    // pending bits: writing zero clears, writing one keeps
    if (wr_pend && !reg_wdata_i[tmr8_pkg::pend_mc_bit]) begin
      next_st.pend_mc = 1'b0;
    end
    if (wr_pend && !reg_wdata_i[tmr8_pkg::pend_ov_bit]) begin
      next_st.pend_ov = 1'b0;
    end
    // counter per mode
    if (tick) begin
      case (mode)
        tmr8_pkg::mode_interval: begin
          if (match) begin
            next_st.cnt = tmr8_pkg::count_rst;
            next_st.tgl = !st.tgl;
          end else begin
            next_st.cnt = st.cnt + 8'h01;
          end
        end
        default: next_st.cnt = st.cnt + 8'h01; // free run, wraps
      endcase
    end
    // captured count overrides a software write
    if (cap_ev) begin
      next_st.refv = st.cnt;
    end
    // clear strobe wins over counting in any mode
    if (wr_ctl && reg_wdata_i[tmr8_pkg::clear_bit]) begin
      next_st.cnt = tmr8_pkg::count_rst;
    end
    // pwm level, low while reference not above count
    if (mode == tmr8_pkg::mode_pwm) begin
      next_st.pwm = (st.refv > st.cnt);
    end else begin
      next_st.pwm = 1'b0;
    end
    // hardware set wins over software clear
    if (mc_ev) begin
      next_st.pend_mc = 1'b1;
    end
    if (ov_ev) begin
      next_st.pend_ov = 1'b1;
    end
    // read data, answered the cycle after the strobe
    if (reg_rd_i) begin
      case (reg_addr_i)
        tmr8_pkg::timer_control_off: next_st.rdata = st.ctl;
        tmr8_pkg::timer_count_value_off: next_st.rdata = st.cnt;
        tmr8_pkg::timer_reference_value_off: next_st.rdata = st.refv;
        tmr8_pkg::port_control_mid_off: next_st.rdata = st.portc;
        tmr8_pkg::shared_pending_flags_off: begin
          next_st.rdata = 8'h00;
          next_st.rdata[tmr8_pkg::pend_mc_bit] = st.pend_mc;
          next_st.rdata[tmr8_pkg::pend_ov_bit] = st.pend_ov;
        end
        default: next_st.rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st.ctl <= tmr8_pkg::timer_control_rst;
      st.cnt <= tmr8_pkg::count_rst;
      st.refv <= tmr8_pkg::reference_rst;
      st.portc <= tmr8_pkg::port_control_mid_rst;
      st.pend_mc <= 1'b0;
      st.pend_ov <= 1'b0;
      st.tgl <= 1'b0;
      st.pwm <= 1'b0;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o = st.rdata;
  assign toggle_output_pin_o = st.tgl;
  assign pulse_output_pin_o = st.pwm;
  assign match_capture_irq_o = st.pend_mc;
  assign overflow_irq_o = st.pend_ov;

  // checks on the timer behaviour
  reset_ctl_a: assert property (@(posedge mclk_i) $rose(rst_b_i) |-> st.ctl == 8'h00)
    else $error("control not zero after reset");

  div8_gap_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    tick && st.ctl[7:5] == 3'h3 |=> (!tick || st.ctl[7:5] != 3'h3) [*7])
    else $error("divide by 8 tick spacing wrong");

  clear_cnt_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_ctl && reg_wdata_i[2] |=> st.cnt == 8'h00)
    else $error("counter not cleared by control write");

  mie_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(st.pend_mc) |-> $past(st.ctl[1]))
    else $error("match request without enable");

  pend_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_pend && !reg_wdata_i[4] && !mc_ev |=> !st.pend_mc)
    else $error("pending bit not cleared");

  match_reset_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    match && mode == tmr8_pkg::mode_interval && !wr_ctl |=> st.cnt == 8'h00 && (st.pend_mc || !$past(st.ctl[1])))
    else $error("interval match did not reset counter");

  toggle_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    match && mode == tmr8_pkg::mode_interval |=> st.tgl != $past(st.tgl))
    else $error("toggle output did not invert");

  pwm_wrap_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    tick && mode == tmr8_pkg::mode_pwm && st.cnt == 8'hff && !wr_ctl |=> st.cnt == 8'h00)
    else $error("pwm counter did not wrap");

  pwm_level_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    mode == tmr8_pkg::mode_pwm |=> st.pwm == ($past(st.refv) > $past(st.cnt)))
    else $error("pwm level wrong");

  capture_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    cap_ev |=> st.refv == $past(st.cnt) ##0 (st.pend_mc || !$past(st.ctl[1])))
    else $error("capture did not load count");

  overflow_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wrap && st.ctl[0] |=> st.pend_ov)
    else $error("overflow request missing");

  // reset leaves the counter at zero and both requests low
  reset_state_a: assert property (@(posedge mclk_i) $rose(rst_b_i) |->
    st.cnt == 8'h00 && !st.pend_mc && !st.pend_ov && !st.tgl && !st.pwm)
    else $error("state not cleared after reset");

  // undivided ratio gives a tick on every cycle
  div1_tick_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $past(st.ctl[7:5]) == 3'h4 |-> tick)
    else $error("undivided ratio missed a tick");

  // free-running modes step the count by one per tick
  count_step_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    tick && mode != tmr8_pkg::mode_interval && !wr_ctl |=> st.cnt == $past(st.cnt) + 8'h01)
    else $error("counter did not step by one");

  // a pwm match leaves the counter running
  pwm_match_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    match && mode == tmr8_pkg::mode_pwm && st.cnt != 8'hff && !wr_ctl |=> st.cnt != 8'h00)
    else $error("pwm match cleared the counter");

  // a non-pin capture source keeps capture idle
  cap_source_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    st.portc[3:2] != 2'h0 |-> !cap_ev)
    else $error("capture taken from unselected source");

  // each capture load into the reference with bit 1 set raises the capture request
  cap_request_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    cap_ev && st.ctl[1] |=> st.pend_mc)
    else $error("capture request missing");

  // overflow request only when its enable was set
  ovf_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(st.pend_ov) |-> $past(st.ctl[0]))
    else $error("overflow request without enable");

  // pending register read shows the match/capture bit
  pend_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == 8'hc1 |=> st.rdata[4] == $past(st.pend_mc))
    else $error("pending bit read back wrong");

  // control reads back without the clear strobe
  ctl_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == 8'hbe |=> st.rdata[2] == 1'b0)
    else $error("clear strobe read back as one");

  // main scenarios reached
  match_seen_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    match && mode == tmr8_pkg::mode_interval);
  overflow_seen_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i) ov_ev);
  capture_seen_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i) cap_ev);
  pwm_wrap_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    wrap && mode == tmr8_pkg::mode_pwm);
endmodule : tmr8_timer

// ### verilog/tmr8_pkg.sv
/*
  constants, register map and state types for the 8-bit timer with
  interval, pwm and capture modes.
  assumes one clock domain and a byte-wide register port.
*/
package tmr8_pkg;
  // register offsets on the byte-wide register port
  localparam logic [7:0] timer_control_off = 8'hbe;
  localparam logic [7:0] timer_count_value_off = 8'hbf;
  localparam logic [7:0] timer_reference_value_off = 8'hc0;
  localparam logic [7:0] shared_pending_flags_off = 8'hc1;
  localparam logic [7:0] port_control_mid_off = 8'hf9;
  // timer_control fields
  localparam int clk_sel_lsb = 5; // bits 7:5 clock select
  localparam int mode_lsb = 3; // bits 4:3 mode and capture edge
  localparam int clear_bit = 2; // write one clears counter
  localparam int match_ie_bit = 1; // match/capture request enable
  localparam int ovf_ie_bit = 0; // overflow request enable
  // shared_pending_flags fields
  localparam int pend_mc_bit = 4;
  localparam int pend_ov_bit = 5;
  // port_control_mid capture select field, bits 3:2
  localparam int cap_sel_lsb = 2;
  localparam logic [1:0] cap_sel_pin = 2'h0;
  // reset values
  localparam logic [7:0] timer_control_rst = 8'h00;
  localparam logic [7:0] port_control_mid_rst = 8'h00;
  localparam logic [7:0] count_rst = 8'h00;
  localparam logic [7:0] reference_rst = 8'hff;
  localparam logic [7:0] count_max = 8'hff;
  // clock select codes
  localparam logic [2:0] div_1024 = 3'h0;
  localparam logic [2:0] div_256 = 3'h1;
  localparam logic [2:0] div_64 = 3'h2;
  localparam logic [2:0] div_8 = 3'h3;
  localparam logic [2:0] div_1 = 3'h4;
  // prescaler terminal counts
  localparam logic [9:0] term_1024 = 10'h3ff;
  localparam logic [7:0] term_256 = 8'hff;
  localparam logic [5:0] term_64 = 6'h3f;
  localparam logic [2:0] term_8 = 3'h7;

  // operating modes
  typedef enum logic [1:0] {
    mode_interval,
    mode_cap_rise,
    mode_cap_fall,
    mode_pwm
  } tmr_mode_t;

  // prescaler state
  typedef struct packed {
    logic [9:0] div;
    logic tick;
  } presc_state_t;

  // pin synchroniser state
  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
    logic rise;
    logic fall;
  } sync_state_t;

  // timer core state
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] cnt;
    logic [7:0] refv;
    logic [7:0] portc;
    logic pend_mc;
    logic pend_ov;
    logic tgl;
    logic pwm;
    logic [7:0] rdata;
  } timer_state_t;
endpackage : tmr8_pkg

// ### verilog/tmr8_prescaler.sv
/*
  free-running divider with a select multiplexer, giving one-cycle
  count ticks at the system clock divided by 1024, 256, 64, 8 or 1.
  assumes sel_i comes from a register on the same clock.
*/
`timescale 1ns/1ps
module tmr8_prescaler (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // ratio select
  input wire logic [2:0] sel_i,
  // count enable pulse
  output logic tick_o
);
  tmr8_pkg::presc_state_t st; // registered state
  tmr8_pkg::presc_state_t next_st; // next state

  // divider and multiplexer after it
  always_comb begin
    next_st = st;
    next_st.div = st.div + 10'h001;
    case (sel_i)
      tmr8_pkg::div_1024: next_st.tick = (st.div == tmr8_pkg::term_1024);
      tmr8_pkg::div_256: next_st.tick = (st.div[7:0] == tmr8_pkg::term_256);
      tmr8_pkg::div_64: next_st.tick = (st.div[5:0] == tmr8_pkg::term_64);
      tmr8_pkg::div_8: next_st.tick = (st.div[2:0] == tmr8_pkg::term_8);
      default: next_st.tick = 1'b1; // undefined codes run undivided
    endcase
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;
endmodule : tmr8_prescaler

// ### verilog/tmr8_pin_sync.sv
/*
  three-stage synchroniser for the capture pin with edge pulses.
  assumes the pin is asynchronous to mclk_i.
*/
`timescale 1ns/1ps
module tmr8_pin_sync (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // raw pin
  input wire logic pin_i,
  // filtered edges
  output logic rise_o,
  output logic fall_o
);
  tmr8_pkg::sync_state_t st; // registered state
  tmr8_pkg::sync_state_t next_st; // next state

  // change accepted once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.sh = {st.sh[1:0], pin_i};
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if (st.sh[1] == st.sh[2] && st.sh[2] != st.lvl) begin
      next_st.lvl = st.sh[2];
      next_st.rise = st.sh[2];
      next_st.fall = !st.sh[2];
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise_o = st.rise;
  assign fall_o = st.fall;
endmodule : tmr8_pin_sync

// ### verification/tmr8_pin_model.sv
/*
  capture pin source standing outside the timer: follows the level
  asked by the bench after a prompt or a slow delay.
  assumes mclk_i is the timer clock and the bench holds each level long.
*/
`timescale 1ns/1ps
module tmr8_pin_model (
  // clock
  input wire logic mclk_i,
  // level request from the bench
  input wire logic want_i,
  input wire logic slow_i,
  // capture pin
  output logic pin_o
);
  int unsigned wait_cnt = 0; // cycles since the request differed
  initial pin_o = 1'b0;
  // move the pin only after the chosen delay, like a real source
  always @(posedge mclk_i) begin
    if (want_i == pin_o) begin
      wait_cnt <= 0;
    end else if (wait_cnt >= (slow_i ? 7 : 1)) begin
      pin_o <= want_i;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : tmr8_pin_model

// ### verification/eight_bit_timer_pwm_capture_test.sv
/*
  self-checking bench for the 8-bit timer: register port, ratios,
  interval, pwm, capture and overflow.
  assumes tmr8_timer and tmr8_pin_model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("mismatch %0t %h exp %h", $time, a, e); end end
module eight_bit_timer_pwm_capture_test;
  // design ports
  logic mclk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic capture_input_pin_i, toggle_output_pin_o, pulse_output_pin_o, match_capture_irq_o, overflow_irq_o;
  // bench state
  logic want = 0, slow = 0, rd_d = 0, mv = 0;
  logic [7:0] mval = 8'h00, got, cnt, rv;
  logic [15:0] notes[$]; // mask and expected value
  int errors = 0, compares = 0, n, per;
  int ratio[5] = '{1024, 256, 64, 8, 1};
  logic [7:0] pw[3];
  tmr8_timer DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .capture_input_pin_i(capture_input_pin_i), .toggle_output_pin_o(toggle_output_pin_o),
    .pulse_output_pin_o(pulse_output_pin_o), .match_capture_irq_o(match_capture_irq_o),
    .overflow_irq_o(overflow_irq_o));
  tmr8_pin_model pin (.mclk_i(mclk_i), .want_i(want), .slow_i(slow), .pin_o(capture_input_pin_i));
  initial forever #20 mclk_i = ~mclk_i;
  // results arrive as read data or measured values, oldest note first
  always @(posedge mclk_i) begin
    logic [15:0] nt;
    if (rd_d || mv) begin
      nt = notes.pop_front();
      `CHK((rd_d ? reg_rdata_o : mval) & nt[15:8], nt[7:0])
    end
    rd_d <= reg_rd_i;
  end
  // one register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // one register read, noting the masked expectation
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge mclk_i);
    notes.push_back({m, e});
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
    got = reg_rdata_o;
  endtask : rd
  // hand a measured value to the watcher
  task automatic meas(input logic [7:0] act, input logic [7:0] e);
    @(posedge mclk_i);
    notes.push_back({8'hff, e});
    mval <= act;
    mv <= 1'b1;
    @(posedge mclk_i);
    mv <= 1'b0;
  endtask : meas
  // cycles until the toggle output changes
  task automatic gap(output int c);
    logic t;
    t = toggle_output_pin_o;
    c = 0;
    do begin
      @(posedge mclk_i);
      #1 c++;
    end while (toggle_output_pin_o === t && c < 3000);
  endtask : gap
  // bounded wait for a request line
  task automatic wait_hi(input bit ov);
    n = 0;
    while ((ov ? overflow_irq_o : match_capture_irq_o) !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      #1 n++;
    end
  endtask : wait_hi
  task automatic results();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // watchdog well past the expected run
  initial begin
    #(60000 * 40);
    errors++;
    results();
  end
  // main sequence
  initial begin
    n = $urandom(32'h8262);
    pw = '{8'h00, 8'($urandom % 254 + 1), 8'hff};
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(8'hbe, 8'h00);
    rd(8'hc0, 8'hff);
    rd(8'hc1, 8'h00);
    rd(8'hf9, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'hbf, 8'h55);
    rd(8'hbf, 8'h00, 8'hf0);
    $display("reset done");
    // interval with reference 0 toggles once per tick
    wr(8'hc0, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(8'hbe, {i[2:0], 5'h00});
      gap(per);
      gap(per);
      meas({7'h0, per == ratio[i]}, 8'h01);
    end
    $display("ratios done");
    wr(8'hc0, 8'h02);
    wr(8'hbe, 8'h80);
    wr(8'hc1, 8'h00);
    repeat (20) @(posedge mclk_i);
    meas({7'h0, match_capture_irq_o}, 8'h00);
    gap(per);
    gap(per);
    meas({7'h0, per == 3}, 8'h01);
    wr(8'hbe, 8'h82);
    wait_hi(0);
    meas({7'h0, match_capture_irq_o}, 8'h01);
    wr(8'hbe, 8'h00);
    wr(8'hc1, 8'h00);
    rd(8'hc1, 8'h00);
    $display("interval done");
    // high cycles in one 256-tick period equal the reference
    for (int i = 0; i < 3; i++) begin
      wr(8'hc0, pw[i]);
      wr(8'hbe, 8'h98);
      repeat (300) @(posedge mclk_i);
      n = 0;
      repeat (256) begin
        @(posedge mclk_i);
        #1 n += pulse_output_pin_o;
      end
      meas(8'(n), pw[i]);
    end
    wr(8'hbe, 8'h1c);
    rd(8'hbe, 8'h18);
    rd(8'hbf, 8'h00, 8'hf0);
    $display("pwm done");
    // rising then falling capture at divide 64
    for (int i = 0; i < 2; i++) begin
      want <= (i == 1);
      slow <= i[0];
      repeat (20) @(posedge mclk_i);
      wr(8'hbe, i ? 8'h52 : 8'h4a);
      wr(8'hc1, 8'h00);
      repeat (100) @(posedge mclk_i);
      want <= (i == 0);
      wait_hi(0);
      rd(8'hc0, 8'h00, 8'h00);
      rv = got;
      rd(8'hbf, 8'h00, 8'h00);
      cnt = got;
      meas({7'h0, (cnt - rv) <= 8'h01}, 8'h01);
      wr(8'hc1, 8'h10);
      rd(8'hc1, 8'h10, 8'h10);
      want <= (i == 1);
      repeat (20) @(posedge mclk_i);
      wr(8'hf9, 8'h04);
      wr(8'hc1, 8'h00);
      want <= (i == 0);
      repeat (40) @(posedge mclk_i);
      meas({7'h0, match_capture_irq_o}, 8'h00);
      wr(8'hf9, 8'h00);
    end
    $display("capture done");
    wr(8'hbe, 8'h88);
    wr(8'hc1, 8'h00);
    repeat (300) @(posedge mclk_i);
    meas({7'h0, overflow_irq_o}, 8'h00);
    wr(8'hbe, 8'h89);
    wait_hi(1);
    meas({7'h0, overflow_irq_o}, 8'h01);
    $display("overflow done");
    results();
  end
endmodule : eight_bit_timer_pwm_capture_test
